//--- hdl/msq_conv_timer.sv
`timescale 1ns/100ps
module msq_conv_timer
  import msq_pkg::*;
#(
  parameter int WIDTH = 20
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  // status
  output logic                  expired
);

  logic [WIDTH-1:0] count_ff;  // cycles left, zero when idle

  // ----------------------------------------
  // down counter
  // ----------------------------------------
  // load wins over counting so a restart is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= load_value;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  // last cycle of the interval, a count of n gives n cycles; load stays out, it is fed back from here
  assign expired = (count_ff == WIDTH'(1));

endmodule : msq_conv_timer

//--- hdl/msq_measurement_sequencer.sv
`timescale 1ns/100ps
// Behaviour
// - temperature resolution 9, 11 or 14 bits
// - humidity resolution chosen independently
// - conversion time follows selected resolution
// - on demand, convert only on command
// - stay asleep after on-demand conversion
// - auto mode starts measurements itself
// - seven rates, two minutes to 5/s
// - wake into measurement each interval
// - software heater control, measuring still possible
// - sleep at reset and after storing
// - set done flag when reporting enabled
module msq_measurement_sequencer
  import msq_pkg::*;
#(
  parameter int CYCLES_PER_US = MSQ_CLK_MHZ,    // shorten in simulation
  parameter int CYCLES_PER_MS = MSQ_CLK_PER_MS, // shorten in simulation
  parameter int TIMER_WIDTH   = 20
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // sensor front end
  input  wire logic [15:0] temp_sample,
  input  wire logic [15:0] hum_sample,
  output logic             temp_conv_on,
  output logic             hum_conv_on,
  // heater and interrupt
  output logic             heater_en,
  output logic             irq
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  msq_state_t             state_ff;       // sequencer state
  msq_state_t             nxt_state;
  logic [8:0]             cfg_ff;         // configuration word
  logic [0:0]             irq_stat_ff;    // sticky events
  logic [0:0]             irq_mask_ff;    // event enables
  logic [15:0]            temp_data_ff;   // stored temperature
  logic [15:0]            hum_data_ff;    // stored humidity
  logic [31:0]            prdata_ff;      // read data, taken in setup
  logic [1:0]             tres_ff;        // resolution latched at start
  logic [1:0]             hres_ff;
  logic [2:0]             rate;           // 0 = on demand
  logic                   wr_acc;         // write access phase
  logic                   cmd_start;      // software start pulse
  logic                   auto_tick;      // interval elapsed
  logic                   start_req;      // any start request
  logic                   conv_load;      // load conversion timer
  logic [TIMER_WIDTH-1:0] conv_len;       // cycles for next conversion
  logic                   conv_done;      // timer expired
  logic                   addr_ok;        // address is mapped
  logic [2:0]             rate_last_ff;   // rate seen last cycle
  logic [31:0]            pre_cnt_ff;     // cycles within a millisecond
  logic [31:0]            ms_cnt_ff;      // milliseconds elapsed
  logic [31:0]            ivl_ms;         // interval for current rate

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // conversion length in cycles for a resolution code
  function automatic logic [TIMER_WIDTH-1:0] conv_cycles(input logic [1:0] res, input logic hum);
    int us = 0;
    unique case (res)
      MSQ_RES_9:  us = hum ? MSQ_HUM_US_9 : MSQ_TEMP_US_9;
      MSQ_RES_11: us = hum ? MSQ_HUM_US_11 : MSQ_TEMP_US_11;
      default:    us = hum ? MSQ_HUM_US_14 : MSQ_TEMP_US_14;
    endcase
    return TIMER_WIDTH'(us * CYCLES_PER_US);
  endfunction : conv_cycles
  // keep only the top bits that the resolution produces
  function automatic logic [15:0] res_keep(input logic [1:0] res);
    unique case (res)
      MSQ_RES_9:  return 16'hff80;
      MSQ_RES_11: return 16'hffe0;
      default:    return 16'hfffc;
    endcase
  endfunction : res_keep

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign wr_acc    = psel && penable && pwrite;
  assign cmd_start = wr_acc && (paddr == MSQ_OFS_COMMAND) && pwdata[MSQ_CMD_START];
  assign addr_ok   = (paddr <= MSQ_OFS_HUM) && (paddr[1:0] == 2'h0);  // map is dense and word aligned
  // zero wait states, error only for an unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_ff;

  // read data captured in setup so it stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        MSQ_OFS_CONFIG:   prdata_ff <= 32'(cfg_ff);
        MSQ_OFS_STATUS:   prdata_ff <= {28'h0, heater_en, hum_conv_on, temp_conv_on, state_ff != MSQ_SLEEP};
        MSQ_OFS_IRQ_STAT: prdata_ff <= 32'(irq_stat_ff);
        MSQ_OFS_IRQ_MASK: prdata_ff <= 32'(irq_mask_ff);
        MSQ_OFS_TEMP:     prdata_ff <= {16'h0, temp_data_ff};
        MSQ_OFS_HUM:      prdata_ff <= {16'h0, hum_data_ff};
        default:          prdata_ff <= '0;  // command and unmapped read zero
      endcase
    end
  end

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  // all fields, written together as one word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= MSQ_CFG_RESET;
    end else if (wr_acc && (paddr == MSQ_OFS_CONFIG)) begin
      cfg_ff <= pwdata[MSQ_CFG_WIDTH-1:0];
    end
  end

  assign rate      = cfg_ff[MSQ_CFG_RATE_LSB +: 3];
  assign heater_en = cfg_ff[MSQ_CFG_HEAT_BIT];

  // ----------------------------------------
  // interrupt mask
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= MSQ_MASK_RESET;
    end else if (wr_acc && (paddr == MSQ_OFS_IRQ_MASK)) begin
      irq_mask_ff <= pwdata[MSQ_IRQ_WIDTH-1:0];
    end
  end

  // ----------------------------------------
  // sticky status, write one to clear
  // ----------------------------------------
  // done flag set on store when reporting is enabled
  // a completion in the clearing cycle still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
    end else if (state_ff == MSQ_STORE && cfg_ff[MSQ_CFG_DRDY_BIT]) begin
      irq_stat_ff[MSQ_IRQ_DONE] <= 1'b1;
    end else if (wr_acc && (paddr == MSQ_OFS_IRQ_STAT)) begin
      irq_stat_ff <= irq_stat_ff & ~pwdata[MSQ_IRQ_WIDTH-1:0];
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ----------------------------------------
  // auto sampling interval
  // ----------------------------------------
  // seven interval choices
  always_comb begin
    unique case (rate)
      3'h1:    ivl_ms = 32'(MSQ_IVL_MS_1);
      3'h2:    ivl_ms = 32'(MSQ_IVL_MS_2);
      3'h3:    ivl_ms = 32'(MSQ_IVL_MS_3);
      3'h4:    ivl_ms = 32'(MSQ_IVL_MS_4);
      3'h5:    ivl_ms = 32'(MSQ_IVL_MS_5);
      3'h6:    ivl_ms = 32'(MSQ_IVL_MS_6);
      3'h7:    ivl_ms = 32'(MSQ_IVL_MS_7);
      default: ivl_ms = 32'h0;
    endcase
  end

  // restart the interval whenever the rate changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_last_ff <= '0;
    end else begin
      rate_last_ff <= rate;
    end
  end

  // prescaler to milliseconds, then count milliseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_ff <= '0;
      ms_cnt_ff  <= '0;
    end else if (rate == 3'h0 || rate != rate_last_ff) begin
      pre_cnt_ff <= '0;
      ms_cnt_ff  <= '0;
    end else if (pre_cnt_ff == 32'(CYCLES_PER_MS - 1)) begin
      pre_cnt_ff <= '0;
      ms_cnt_ff  <= auto_tick ? 32'h0 : ms_cnt_ff + 32'h1;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 32'h1;
    end
  end

  assign auto_tick = (rate != 3'h0) && (rate == rate_last_ff) &&
                     (pre_cnt_ff == 32'(CYCLES_PER_MS - 1)) && (ms_cnt_ff == ivl_ms - 32'h1);
  // command or tick is the only trigger
  assign start_req = cmd_start || auto_tick;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      MSQ_SLEEP:     if (start_req) nxt_state = MSQ_CONV_TEMP;
      MSQ_CONV_TEMP: if (conv_done) nxt_state = MSQ_CONV_HUM;
      MSQ_CONV_HUM:  if (conv_done) nxt_state = MSQ_STORE;
      MSQ_STORE:     nxt_state = MSQ_SLEEP;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= MSQ_SLEEP;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // resolution frozen for the whole measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tres_ff <= MSQ_RES_14;
      hres_ff <= MSQ_RES_14;
    end else if (state_ff == MSQ_SLEEP && start_req) begin
      tres_ff <= cfg_ff[MSQ_CFG_TRES_LSB +: 2];
      hres_ff <= cfg_ff[MSQ_CFG_HRES_LSB +: 2];
    end
  end
  assign conv_load = (state_ff == MSQ_SLEEP && start_req) ||
                     (state_ff == MSQ_CONV_TEMP && conv_done);
  assign conv_len  = conv_cycles((state_ff == MSQ_SLEEP) ? cfg_ff[MSQ_CFG_TRES_LSB +: 2] : hres_ff,
                                 state_ff != MSQ_SLEEP);
  msq_conv_timer #(
    .WIDTH      (TIMER_WIDTH)
  ) u_conv_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (conv_load),
    .load_value (conv_len),
    .expired    (conv_done)
  );
  assign temp_conv_on = (state_ff == MSQ_CONV_TEMP);
  assign hum_conv_on  = (state_ff == MSQ_CONV_HUM);

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // low bits cleared below resolution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_data_ff <= '0;
      hum_data_ff  <= '0;
    end else if (state_ff == MSQ_STORE) begin
      temp_data_ff <= temp_sample & res_keep(tres_ff);
      hum_data_ff  <= hum_sample & res_keep(hres_ff);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  int unsigned dwell_ff;         // cycles spent in current state
  int unsigned exp_len;          // expected dwell of current state

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell_ff <= 0;
    end else if (nxt_state != state_ff) begin
      dwell_ff <= 0;
    end else begin
      dwell_ff <= dwell_ff + 1;
    end
  end
  assign exp_len = 32'(conv_cycles((state_ff == MSQ_CONV_TEMP) ? tres_ff : hres_ff, state_ff != MSQ_CONV_TEMP));

  sequence s_measure;
    state_ff == MSQ_CONV_TEMP;
  endsequence

  property p_wake(trig);
    @(posedge pclk) disable iff (!presetn)
      (state_ff == MSQ_SLEEP && trig) |=> s_measure;
  endproperty

  chk_demand_wake: assert property (p_wake(cmd_start))
    else $error("command in sleep did not start a conversion");
  chk_auto_wake: assert property (p_wake(auto_tick))
    else $error("interval tick did not start a conversion");
  chk_heater_meas: assert property (p_wake(cmd_start && heater_en))
    else $error("conversion blocked while heater on");
  chk_stay_asleep: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == MSQ_SLEEP && !start_req) |=> state_ff == MSQ_SLEEP)
    else $error("left sleep without a start request");
  chk_store_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == MSQ_STORE |=> state_ff == MSQ_SLEEP)
    else $error("stored result did not return to sleep");
  chk_meas_bound: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff != MSQ_SLEEP |-> dwell_ff < 32'(conv_cycles(MSQ_RES_14, 1'b1)))
    else $error("measurement phase outlasted the longest conversion");
  chk_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == MSQ_CONV_HUM && start_req && !conv_done) |=> $stable(state_ff) && $stable(tres_ff))
    else $error("start request disturbed a running conversion");
  chk_conv_time: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == MSQ_CONV_TEMP && nxt_state != state_ff) |-> dwell_ff + 1 == exp_len)
    else $error("temperature conversion length wrong");
  chk_hum_time: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == MSQ_CONV_HUM && nxt_state != state_ff) |-> dwell_ff + 1 == exp_len)
    else $error("humidity conversion length wrong");
  chk_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == MSQ_STORE && cfg_ff[MSQ_CFG_DRDY_BIT]) |=> irq_stat_ff[MSQ_IRQ_DONE])
    else $error("done flag not set after conversion");
  chk_res_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == MSQ_STORE && tres_ff == MSQ_RES_9) |=> temp_data_ff[6:0] == 7'h00)
    else $error("9 bit temperature keeps low bits");
  chk_auto_only: assert property (@(posedge pclk) disable iff (!presetn)
    auto_tick |-> rate != 3'h0 && $past(pre_cnt_ff) == 32'(CYCLES_PER_MS - 2))
    else $error("auto tick outside auto mode");

endmodule : msq_measurement_sequencer

//--- hdl/msq_pkg.sv
package msq_pkg;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] MSQ_OFS_CONFIG   = 8'h00;  // rate, resolutions, heater, done reporting
  localparam logic [7:0] MSQ_OFS_COMMAND  = 8'h04;  // write one to bit 0 to start
  localparam logic [7:0] MSQ_OFS_STATUS   = 8'h08;  // live sequencer state
  localparam logic [7:0] MSQ_OFS_IRQ_STAT = 8'h0c;  // sticky events, write one to clear
  localparam logic [7:0] MSQ_OFS_IRQ_MASK = 8'h10;  // same layout as irq status
  localparam logic [7:0] MSQ_OFS_TEMP     = 8'h14;  // temperature result
  localparam logic [7:0] MSQ_OFS_HUM      = 8'h18;  // humidity result

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int MSQ_CFG_RATE_LSB = 0;  // 3 bits, 0 = on demand
  localparam int MSQ_CFG_TRES_LSB = 3;  // 2 bits temperature resolution
  localparam int MSQ_CFG_HRES_LSB = 5;  // 2 bits humidity resolution
  localparam int MSQ_CFG_HEAT_BIT = 7;  // heater on
  localparam int MSQ_CFG_DRDY_BIT = 8;  // done reporting enable
  localparam int MSQ_CFG_WIDTH    = 9;
  localparam int MSQ_CMD_START    = 0;
  localparam int MSQ_IRQ_DONE     = 0;  // conversion_done_flag
  localparam int MSQ_IRQ_WIDTH    = 1;

  localparam logic [8:0] MSQ_CFG_RESET  = 9'h000;
  localparam logic [0:0] MSQ_MASK_RESET = 1'h0;

  // ----------------------------------------
  // resolution codes
  // ----------------------------------------
  localparam logic [1:0] MSQ_RES_14 = 2'h0;
  localparam logic [1:0] MSQ_RES_11 = 2'h1;
  localparam logic [1:0] MSQ_RES_9  = 2'h2;

  // ----------------------------------------
  // conversion times in microseconds
  // ----------------------------------------
  localparam int MSQ_TEMP_US_9  = 225;
  localparam int MSQ_TEMP_US_11 = 350;
  localparam int MSQ_TEMP_US_14 = 610;
  localparam int MSQ_HUM_US_9   = 275;
  localparam int MSQ_HUM_US_11  = 400;
  localparam int MSQ_HUM_US_14  = 660;
  localparam int MSQ_CLK_MHZ    = 50;    // pclk rate
  localparam int MSQ_CLK_PER_MS = 50000; // pclk cycles per millisecond

  // ----------------------------------------
  // auto sampling intervals in milliseconds
  // ----------------------------------------
  localparam int MSQ_IVL_MS_1 = 120000; // one per two minutes
  localparam int MSQ_IVL_MS_2 = 60000;
  localparam int MSQ_IVL_MS_3 = 10000;
  localparam int MSQ_IVL_MS_4 = 5000;
  localparam int MSQ_IVL_MS_5 = 1000;
  localparam int MSQ_IVL_MS_6 = 500;
  localparam int MSQ_IVL_MS_7 = 200;    // five per second

  typedef enum logic [1:0] {
    MSQ_SLEEP,
    MSQ_CONV_TEMP,
    MSQ_CONV_HUM,
    MSQ_STORE
  } msq_state_t;

endpackage : msq_pkg

//--- tb/msq_front_model.sv
`timescale 1ns/100ps
module msq_front_model
  import msq_pkg::*;
#(
  parameter logic [15:0] TEMP_VAL = 16'hb6d9,  // raw temperature code
  parameter logic [15:0] HUM_VAL  = 16'h5a3f   // raw humidity code
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // conversion strobes
  input  wire logic        temp_conv_on,
  input  wire logic        hum_conv_on,
  // raw results
  output logic [15:0]      temp_sample,
  output logic [15:0]      hum_sample
);
  // ----------------------------------------
  // result hold window
  // ----------------------------------------
  logic [1:0] hold_ff;  // cycles left of valid result
  logic       valid;    // result lines carry a real code

  // results stay valid only briefly after humidity ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_ff <= 2'h0;
    else if (hum_conv_on)
      hold_ff <= 2'h3;
    else if (hold_ff != 2'h0)
      hold_ff <= hold_ff - 2'h1;
  end

  // outside the window show inverted codes, so a late sample is caught
  assign valid       = temp_conv_on | hum_conv_on | (hold_ff != 2'h0);
  assign temp_sample = valid ? TEMP_VAL : ~TEMP_VAL;
  assign hum_sample  = valid ? HUM_VAL : ~HUM_VAL;
endmodule : msq_front_model

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import msq_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        pclk = 1'b0;      // 50 mhz
  logic        presetn = 1'b0;   // async, active low
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] temp_sample;
  logic [15:0] hum_sample;
  logic        temp_conv_on;
  logic        hum_conv_on;
  logic        heater_en;
  logic        irq;
  int          num_errors = 0;   // mismatches
  int          n_tests = 0;      // comparisons
  logic [31:0] rdv;              // last read data
  logic        erv;              // last error response
  int          w, nt, nh;        // wait and conversion lengths
  localparam logic [15:0] TV = 16'hb6d9;
  localparam logic [15:0] HV = 16'h5a3f;

  typedef struct {
    logic [31:0] cfg;
    logic        mask;
    int          nt;
    int          nh;
    logic [15:0] tm;
    logic [15:0] hm;
  } msq_row_t;
  // resolution pairs, reporting, mask and heater; code 3 reads as 14 bits
  msq_row_t rows [4] = '{
    '{32'h110, 1'b1, 225, 660, 16'hff80, 16'hfffc},
    '{32'h148, 1'b0, 350, 275, 16'hffe0, 16'hff80},
    '{32'h020, 1'b1, 610, 400, 16'hfffc, 16'hffe0},
    '{32'h1f8, 1'b1, 610, 660, 16'hfffc, 16'hfffc}};
  int ivl [3] = '{MSQ_IVL_MS_5, MSQ_IVL_MS_6, MSQ_IVL_MS_7};

  always #10 pclk = ~pclk;

  // ----------------------------------------
  // design and front end
  // ----------------------------------------
  // counts shortened: 1 cycle per us, 20 cycles per ms
  msq_measurement_sequencer #(.CYCLES_PER_US(1), .CYCLES_PER_MS(20), .TIMER_WIDTH(20)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .temp_sample(temp_sample), .hum_sample(hum_sample), .temp_conv_on(temp_conv_on),
    .hum_conv_on(hum_conv_on), .heater_en(heater_en), .irq(irq));
  msq_front_model model_u (
    .pclk(pclk), .presetn(presetn), .temp_conv_on(temp_conv_on), .hum_conv_on(hum_conv_on),
    .temp_sample(temp_sample), .hum_sample(hum_sample));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    erv = pslverr;
    if (n >= 16) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, rdv);
  endtask : rd_chk

  // lengths of the next temperature and humidity phases
  task automatic meas(input int lim);
    w = 0;
    nt = 0;
    nh = 0;
    @(negedge pclk);
    while (temp_conv_on !== 1'b1 && w < lim) begin
      @(negedge pclk);
      w++;
    end
    while (temp_conv_on === 1'b1) begin
      nt++;
      @(negedge pclk);
    end
    while (hum_conv_on === 1'b1) begin
      nh++;
      @(negedge pclk);
    end
  endtask : meas

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // hang guard, well above the expected run length
  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    results();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(MSQ_OFS_STATUS, 32'h0);
    rd_chk(MSQ_OFS_CONFIG, 32'h0);
    rd_chk(MSQ_OFS_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'h1, {31'h0, erv});
    // table cases: resolutions, timing, results, flag, heater
    foreach (rows[i]) begin
      apb(1'b1, MSQ_OFS_IRQ_MASK, {31'h0, rows[i].mask});
      apb(1'b1, MSQ_OFS_CONFIG, rows[i].cfg);
      apb(1'b1, MSQ_OFS_IRQ_STAT, 32'h1);
      chk({31'h0, rows[i].cfg[7]}, {31'h0, heater_en});
      rd_chk(MSQ_OFS_CONFIG, rows[i].cfg);
      apb(1'b1, MSQ_OFS_COMMAND, 32'h1);
      meas(100);
      chk(rows[i].nt, nt);
      chk(rows[i].nh, nh);
      repeat (3) @(negedge pclk);
      rd_chk(MSQ_OFS_TEMP, {16'h0, TV & rows[i].tm});
      rd_chk(MSQ_OFS_HUM, {16'h0, HV & rows[i].hm});
      rd_chk(MSQ_OFS_IRQ_STAT, {31'h0, rows[i].cfg[8]});
      chk({31'h0, rows[i].cfg[8] & rows[i].mask}, {31'h0, irq});
      apb(1'b1, MSQ_OFS_IRQ_STAT, 32'h1);
      // the clear lands on the access edge, look once it has settled
      @(negedge pclk);
      chk(32'h0, {31'h0, irq});
    end
    // starts during a conversion are dropped
    fork
      meas(200);
      begin
        repeat (50) @(posedge pclk);
        apb(1'b1, MSQ_OFS_COMMAND, 32'h1);
        rd_chk(MSQ_OFS_STATUS, 32'hb);
        repeat (700) @(posedge pclk);
        apb(1'b1, MSQ_OFS_COMMAND, 32'h1);
      end
    join
    chk(32'd610, nt);
    chk(32'd660, nh);
    meas(1500);
    chk(32'd0, nt);
    // auto mode first tick for three rates
    foreach (ivl[i]) begin
      apb(1'b1, MSQ_OFS_CONFIG, {29'h0, 3'(5 + i)});
      meas(25000);
      chk(32'h1, {31'h0, (w >= ivl[i] * 20 - 3) && (w <= ivl[i] * 20 + 3)});
      chk(32'd610, nt);
      apb(1'b1, MSQ_OFS_CONFIG, 32'h0);
    end
    // reset in mid conversion
    apb(1'b1, MSQ_OFS_CONFIG, 32'h080);
    apb(1'b1, MSQ_OFS_COMMAND, 32'h1);
    repeat (100) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'h0, {30'h0, temp_conv_on, heater_en});
    presetn <= 1'b1;
    rd_chk(MSQ_OFS_CONFIG, 32'h0);
    results();
  end
endmodule : tb_top
